// [lldmc_pkg.sv]
/*
 Shared constants for the low-latency DRAM mode configuration link:
 command codes, mode field positions, latency table, address mapping.
 Assumes both ends run on one 10 MHz clock with synchronous reset.
*/
`default_nettype none
package lldmc_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W  = 21;
  localparam int BALL_W  = 21;
  localparam int BANK_W  = 3;
  // ==========================================================
  // Commands
  typedef enum logic [2:0] {
    LLDMC_NOP, LLDMC_MODE_LOAD, LLDMC_READ, LLDMC_WRITE, LLDMC_REFRESH
  } lldmc_cmd_t;
  // ==========================================================
  // Mode field positions (non-multiplexed mode word)
  localparam int CFG_LSB   = 0;
  localparam int BURST_LSB = 3;
  localparam int DLL_BIT   = 7;
  localparam int IMP_BIT   = 8;
  localparam int ODT_BIT   = 9;
  localparam int MUX_BIT   = 5;
  localparam logic [2:0] CFG_RST   = 3'h0;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [1:0] BURST_2   = 2'h0;
  localparam logic [1:0] BURST_4   = 2'h1;
  localparam logic [1:0] BURST_8   = 2'h2;
  // Balls that carry address when multiplexed; the rest stay low
  localparam logic [BALL_W-1:0] MUX_BALLS = 21'h066739;
  // ==========================================================
  // Timing
  localparam int DLL_LOCK_CYC   = 1024;
  localparam int MODE_SETTLE_CYC = 6;
  localparam int IMP_PERIOD_CYC = 256;
  localparam logic [3:0] NOM_IMP_CODE = 4'h8;

  // Read latency per configuration; write is one more
  function automatic logic [3:0] lldmc_read_lat(input logic [2:0] cfg,
                                                input logic       mux);
    logic [3:0] rl;
    rl = 4'h4;
    case (cfg)
      3'h2:    rl = 4'h6;
      3'h3:    rl = 4'h8;
      3'h4:    rl = 4'h3;
      3'h5:    rl = 4'h5;
      default: rl = 4'h4;
    endcase
    return rl + {3'h0, mux};
  endfunction

  // Used address width: 21 - burst step, minus one for 18-bit part
  function automatic logic [4:0] lldmc_addr_bits(input logic [1:0] bl,
                                                 input logic       wide);
    return 5'd21 - {3'h0, bl} - {4'h0, wide};
  endfunction
endpackage
`default_nettype wire

// [lldmc_if.sv]
/*
 Command/address link between controller and device.
 Assumes a single shared clock; no tristate here.
*/
`default_nettype none
interface lldmc_if;
  import lldmc_pkg::*;
  lldmc_cmd_t          cmd;
  logic [BALL_W-1:0]   ball;
  logic [BANK_W-1:0]   bank;
  logic                rd_valid;
  modport dev  (input cmd, ball, bank, output rd_valid);
  modport ctrl (output cmd, ball, bank, input rd_valid);
endinterface
`default_nettype wire

// [lldmc_dev.sv]
/*
 Device end: mode register, latency, address capture, DLL lock,
 impedance refresh and termination switching.
 Assumes the controller obeys command spacing on the shared link.
*/
`default_nettype none
module lldmc_dev
  import lldmc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  lldmc_if.dev                   link,
  input  wire logic              wide_part,
  input  wire logic [3:0]        ext_imp_code,
  output logic                   acc_start,
  output logic                   acc_write,
  output logic [ADDR_W-1:0]      acc_addr,
  output logic [BANK_W-1:0]      acc_bank,
  output logic [3:0]             acc_lat,
  output logic [1:0]             burst_sel,
  output logic [4:0]             addr_bits,
  output logic                   dll_locked,
  output logic [3:0]             drive_imp,
  output logic                   term_din,
  output logic                   term_dout,
  output logic                   mux_mode
);
  // ==========================================================
  // Mode register
  logic [2:0]  cfg_r;
  logic [1:0]  bl_r;
  logic        dll_r, imp_r, odt_r, mux_r;
  logic        second_r;
  logic        pend_wr_r;
  logic [BANK_W-1:0] pend_bank_r;
  logic [ADDR_W-1:0] first_r;
  logic [ADDR_W-1:0] ball_ext;
  logic [ADDR_W-1:0] ay_addr;
  assign ball_ext = link.ball;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cfg_r <= CFG_RST;
      bl_r  <= BURST_RST;
      dll_r <= 1'b0;
      imp_r <= 1'b0;
      odt_r <= 1'b0;
      mux_r <= 1'b0;
    end
    else if (link.cmd == LLDMC_MODE_LOAD && !second_r)
    begin
      cfg_r <= link.ball[CFG_LSB +: 3];
      bl_r  <= link.ball[BURST_LSB +: 2];
      dll_r <= link.ball[DLL_BIT];
      imp_r <= link.ball[IMP_BIT];
      odt_r <= link.ball[ODT_BIT];
      mux_r <= link.ball[MUX_BIT];
    end
  end

  // ==========================================================
  // Second address part mapping
  always_comb
  begin
    ay_addr = first_r;
    ay_addr[1]  = link.ball[3];
    ay_addr[2]  = link.ball[4];
    ay_addr[6]  = link.ball[8];
    ay_addr[7]  = link.ball[9];
    ay_addr[11] = link.ball[13];
    ay_addr[12] = link.ball[14];
    ay_addr[16] = link.ball[17];
    ay_addr[15] = link.ball[18];
    ay_addr[19] = 1'b0;
    ay_addr[20] = 1'b0;
    if (!((!wide_part && bl_r == BURST_8) ||
          (wide_part && bl_r != BURST_2)))
      ay_addr[19] = link.ball[10];
    if (!wide_part && bl_r == BURST_2)
      ay_addr[20] = link.ball[0];
  end

  // ==========================================================
  // Address capture
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      second_r    <= 1'b0;
      pend_wr_r   <= 1'b0;
      pend_bank_r <= '0;
      first_r     <= '0;
      acc_start   <= 1'b0;
      acc_write   <= 1'b0;
      acc_addr    <= '0;
      acc_bank    <= '0;
      acc_lat     <= 4'h0;
    end
    else
    begin
      acc_start <= 1'b0;
      second_r  <= 1'b0;
      if (second_r)
      begin
        acc_start <= 1'b1;
        acc_addr  <= ay_addr;
        acc_write <= pend_wr_r;
        acc_bank  <= pend_bank_r;
        acc_lat   <= lldmc_read_lat(cfg_r, 1'b1) +
                     {3'h0, pend_wr_r};
      end
      else if (link.cmd == LLDMC_READ || link.cmd == LLDMC_WRITE)
      begin
        if (mux_r)
        begin
          second_r    <= 1'b1;
          pend_wr_r   <= (link.cmd == LLDMC_WRITE);
          pend_bank_r <= link.bank;
          first_r     <= '0;
          first_r[0]  <= link.ball[0];
          first_r[3]  <= link.ball[3];
          first_r[4]  <= link.ball[4];
          first_r[5]  <= link.ball[5];
          first_r[8]  <= link.ball[8];
          first_r[9]  <= link.ball[9];
          first_r[10] <= link.ball[10];
          first_r[13] <= link.ball[13];
          first_r[14] <= link.ball[14];
          first_r[17] <= link.ball[17];
          first_r[18] <= !(wide_part && bl_r == BURST_8) &&
                         link.ball[18];
        end
        else
        begin
          acc_start <= 1'b1;
          acc_write <= (link.cmd == LLDMC_WRITE);
          acc_bank  <= link.bank;
          acc_addr  <= ball_ext &
                       ((21'h1 << lldmc_addr_bits(bl_r, wide_part))
                        - 21'h1);
          acc_lat   <= lldmc_read_lat(cfg_r, 1'b0) +
                       {3'h0, link.cmd == LLDMC_WRITE};
        end
      end
      // Refresh needs no second cycle, so nothing is pended
    end
  end

  // ==========================================================
  // DLL lock counter
  logic [10:0] lock_cnt_r;
  always_ff @(posedge clk)
  begin
    if (!resetn || !dll_r)
    begin
      lock_cnt_r <= 11'h0;
      dll_locked <= 1'b0;
    end
    else if (lock_cnt_r != 11'(DLL_LOCK_CYC))
    begin
      lock_cnt_r <= lock_cnt_r + 11'h1;
      dll_locked <= 1'b0;
    end
    else
      dll_locked <= 1'b1;
  end

  // ==========================================================
  // Impedance refresh; runs beside commands, never gates them
  logic [7:0] imp_cnt_r;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      imp_cnt_r <= 8'h0;
      drive_imp <= NOM_IMP_CODE;
    end
    else
    begin
      imp_cnt_r <= imp_cnt_r + 8'h1;
      if (imp_cnt_r == 8'(IMP_PERIOD_CYC - 1))
        drive_imp <= imp_r ? ext_imp_code
                           : NOM_IMP_CODE;
    end
  end

  // ==========================================================
  // Termination: read data off while the burst drives
  logic [3:0] rd_busy_r;
  logic [3:0] burst_len;
  assign burst_len = (bl_r == BURST_8) ? 4'h8 :
                     (bl_r == BURST_4) ? 4'h4 : 4'h2;
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rd_busy_r <= 4'h0;
    else if (acc_start && !acc_write)
      rd_busy_r <= burst_len >> 1;
    else if (rd_busy_r != 4'h0)
      rd_busy_r <= rd_busy_r - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      term_din  <= 1'b0;
      term_dout <= 1'b0;
      link.rd_valid <= 1'b0;
    end
    else
    begin
      term_din  <= odt_r;
      term_dout <= odt_r && (rd_busy_r == 4'h0);
      link.rd_valid <= (rd_busy_r != 4'h0);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      burst_sel <= BURST_RST;
      addr_bits <= 5'd21;
      mux_mode  <= 1'b0;
    end
    else
    begin
      burst_sel <= bl_r;
      addr_bits <= lldmc_addr_bits(bl_r, wide_part);
      mux_mode  <= mux_r;
    end
  end
endmodule
`default_nettype wire

// [lldmc_ctrl.sv]
/*
 Controller end: issues mode loads with settle time, DLL lock wait,
 and splits addresses into two parts in multiplexed mode.
 Assumes the user only requests when req_ready is high.
*/
`default_nettype none
module lldmc_ctrl
  import lldmc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  lldmc_if.ctrl                  link,
  input  wire logic              req_valid,
  input  wire lldmc_cmd_t        req_cmd,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [BANK_W-1:0] req_bank,
  input  wire logic [BALL_W-1:0] req_mode,
  output logic                   req_ready,
  output logic                   read_allowed
);
  // ==========================================================
  // Link drive and pacing
  logic        mux_r, second_r, dll_r;
  logic [BALL_W-1:0] ay_r;
  logic [3:0]  settle_r;
  logic [10:0] lock_r;
  logic        go;
  assign go = req_valid && req_ready &&
              !(req_cmd == LLDMC_READ && !read_allowed);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      link.cmd  <= LLDMC_NOP;
      link.ball <= '0;
      link.bank <= '0;
      mux_r     <= 1'b0;
      second_r  <= 1'b0;
      ay_r      <= '0;
      settle_r  <= 4'h0;
      dll_r     <= 1'b0;
      lock_r    <= 11'h0;
    end
    else
    begin
      link.cmd <= LLDMC_NOP;
      second_r <= 1'b0;
      if (settle_r != 4'h0)
        settle_r <= settle_r - 4'h1;
      if (dll_r && lock_r != 11'(DLL_LOCK_CYC))
        lock_r <= lock_r + 11'h1;
      if (second_r)
        link.ball <= ay_r;
      else if (go)
      begin
        link.cmd  <= req_cmd;
        link.bank <= req_bank;
        link.ball <= mux_r ? (req_addr[BALL_W-1:0] & MUX_BALLS)
                           : req_addr[BALL_W-1:0];
        if (req_cmd == LLDMC_MODE_LOAD)
        begin
          link.ball <= req_mode;
          mux_r     <= req_mode[MUX_BIT];
          dll_r     <= req_mode[DLL_BIT];
          // Reload with the loop kept on must not throw away lock
          if (!req_mode[DLL_BIT])
            lock_r  <= 11'h0;
          settle_r  <= 4'(MODE_SETTLE_CYC);
        end
        else if (mux_r && req_cmd != LLDMC_REFRESH)
        begin
          second_r <= 1'b1;
          ay_r     <= '0;
          ay_r[0]  <= req_addr[20];
          ay_r[3]  <= req_addr[1];
          ay_r[4]  <= req_addr[2];
          ay_r[8]  <= req_addr[6];
          ay_r[9]  <= req_addr[7];
          ay_r[10] <= req_addr[19];
          ay_r[13] <= req_addr[11];
          ay_r[14] <= req_addr[12];
          ay_r[17] <= req_addr[16];
          ay_r[18] <= req_addr[15];
        end
      end
    end
  end

  // Blocks while a second part is due or a mode load settles
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      req_ready    <= 1'b0;
      read_allowed <= 1'b0;
    end
    else
    begin
      req_ready <= !(go && (req_cmd == LLDMC_MODE_LOAD ||
                   (mux_r && req_cmd != LLDMC_REFRESH))) &&
                   !second_r && settle_r <= 4'h1;
      read_allowed <= dll_r && lock_r == 11'(DLL_LOCK_CYC)
                      && !(go && req_cmd == LLDMC_MODE_LOAD);
    end
  end
endmodule
`default_nettype wire

// [lldmc_monitor.sv]
/*
 Link checker: command spacing, multiplexed address parts, DLL wait
 and read-valid framing. Takes the link signals as plain inputs.
*/
`default_nettype none
module lldmc_monitor
  import lldmc_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire lldmc_cmd_t        cmd,
  input wire logic [BALL_W-1:0] ball,
  input wire logic [BANK_W-1:0] bank,
  input wire logic              rd_valid
);
  // ==========================================================
  // Helper state
  localparam logic [BALL_W-1:0] SPARE = 21'h1998C6;
  logic        mux_r;
  logic        dll_r;
  logic        rd_seen_r;
  logic [10:0] dll_cnt_r;
  wire logic   acc = (cmd == LLDMC_READ) || (cmd == LLDMC_WRITE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge clk)
    if (!resetn) mux_r <= 1'b0;
    else if (cmd == LLDMC_MODE_LOAD) mux_r <= ball[MUX_BIT];

  // Counter saturates so a long idle never wraps into a false alarm
  always_ff @(posedge clk)
    if (!resetn) dll_cnt_r <= 11'h000;
    else if (cmd == LLDMC_MODE_LOAD && !(dll_r && ball[DLL_BIT]))
      dll_cnt_r <= 11'h000;
    else if (dll_cnt_r != 11'h400) dll_cnt_r <= dll_cnt_r + 11'h001;

  always_ff @(posedge clk)
    if (!resetn) dll_r <= 1'b0;
    else if (cmd == LLDMC_MODE_LOAD) dll_r <= ball[DLL_BIT];

  always_ff @(posedge clk)
    if (!resetn) rd_seen_r <= 1'b0;
    else if (cmd == LLDMC_READ) rd_seen_r <= 1'b1;

  // ==========================================================
  // Assertions
  AST_SETTLE: assert property (cmd == LLDMC_MODE_LOAD |=>
    (cmd == LLDMC_NOP) [*6]) else $error("command inside settle time");
  AST_MODE_IDLE: assert property (cmd == LLDMC_MODE_LOAD |->
    !rd_valid) else $error("mode load during read burst");
  AST_RESET_IDLE: assert property ($rose(resetn) |->
    cmd == LLDMC_NOP) else $error("command at reset release");
  AST_DLL_WAIT: assert property (cmd == LLDMC_READ |->
    dll_r && dll_cnt_r >= 11'h3FF) else $error("read before lock");
  AST_MUX_GAP: assert property (mux_r && acc |=>
    cmd == LLDMC_NOP) else $error("second part cycle not free");
  AST_MUX_BALLS: assert property (mux_r && acc |->
    (ball & SPARE) == '0 ##1 (ball & SPARE) == '0)
    else $error("unused ball driven in multiplexed mode");
  AST_RDV_CAUSE: assert property ($rose(rd_valid) |->
    rd_seen_r) else $error("read valid with no read");
  AST_RDV_END: assert property ($rose(rd_valid) |->
    ##[1:8] !rd_valid) else $error("read valid never drops");
  AST_RDV_LAT: assert property (cmd == LLDMC_READ |->
    ##[2:14] rd_valid) else $error("read valid missing");

  cover property (cmd == LLDMC_MODE_LOAD);
  cover property (mux_r && cmd == LLDMC_WRITE);
  cover property (cmd == LLDMC_REFRESH ##1 cmd == LLDMC_REFRESH);
endmodule
`default_nettype wire

// [tb_top.sv]
/*
 Self-checking bench: controller and device joined by the link.
 Assumes the package constants and a 10 MHz clock.
*/
`default_nettype none
module tb_top
  import lldmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              wide_part = 1'b0;
  logic [3:0]        ext_imp_code = 4'h0;
  logic              req_valid = 1'b0;
  lldmc_cmd_t        req_cmd = LLDMC_NOP;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [BANK_W-1:0] req_bank = 3'h5;
  logic [BALL_W-1:0] req_mode = '0;
  logic              req_ready, read_allowed, acc_start, dll_locked;
  logic              acc_write, wr_s;
  logic [ADDR_W-1:0] acc_addr, addr_s;
  logic [BANK_W-1:0] acc_bank, bank_s;
  logic [3:0]        acc_lat, lat_s, drive_imp;
  logic [1:0]        burst_sel;
  logic [4:0]        addr_bits;
  logic              term_din, term_dout, mux_mode, pend = 1'b0;
  logic [BALL_W-1:0] ax_s, ay_s;
  logic              odt_on = 1'b0;
  int                err_count = 0, checks = 0, n_acc = 0, n_off = 0;
  int                cyc = 0, ref_last = 0, ref_gap = 0;
  logic [3:0]        rl_tab [6] = '{4'h4, 4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
  localparam logic [20:0] A = 21'h1A5C3B;

  lldmc_if link();
  lldmc_ctrl lldmc_ctrl_inst (.clk, .resetn, .link, .req_valid, .req_cmd,
    .req_addr, .req_bank, .req_mode, .req_ready, .read_allowed);
  lldmc_dev lldmc_dev_inst (.clk, .resetn, .link, .wide_part,
    .ext_imp_code, .acc_start, .acc_write, .acc_addr, .acc_bank,
    .acc_lat, .burst_sel, .addr_bits, .dll_locked, .drive_imp, .term_din,
    .term_dout, .mux_mode);
  lldmc_monitor lldmc_monitor_inst (.clk, .resetn, .cmd(link.cmd),
    .ball(link.ball), .bank(link.bank), .rd_valid(link.rd_valid));

  always #50 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Holds the request until the edge that samples ready high
  task automatic req(input lldmc_cmd_t c, input logic [20:0] a,
                     input logic [BALL_W-1:0] m);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_mode <= m;
    do @(posedge clk); while (req_ready !== 1'b1);
  endtask

  task automatic idle();
    req_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic go(input lldmc_cmd_t c, input logic [20:0] a);
    int n0;
    n0 = n_acc;
    req(c, a, '0);
    idle();
    for (int i = 0; i < 20 && n_acc == n0; i++) @(posedge clk);
  endtask

  // Quiet gap first so no burst is in flight at the load
  task automatic mode(input logic [BALL_W-1:0] m);
    repeat (16) @(posedge clk);
    req(LLDMC_MODE_LOAD, '0, m);
    idle();
    repeat (10) @(posedge clk);
  endtask

  function automatic logic [BALL_W-1:0] mw(input logic [2:0] c,
    input logic [1:0] b, input logic x, d, i);
    mw = '0;
    mw[CFG_LSB +: 3] = c;
    mw[BURST_LSB +: 2] = b;
    {mw[MUX_BIT], mw[DLL_BIT], mw[IMP_BIT], mw[ODT_BIT]} = {x, d, i, 1'b1};
  endfunction

  function automatic logic [18:0] ay_exp(input logic [20:0] a);
    ay_exp = '0;
    {ay_exp[0], ay_exp[3], ay_exp[4], ay_exp[8]} = {a[20], a[1], a[2], a[6]};
    {ay_exp[9], ay_exp[10]} = {a[7], a[19]};
    {ay_exp[13], ay_exp[14]} = {a[11], a[12]};
    {ay_exp[17], ay_exp[18]} = {a[16], a[15]};
  endfunction

  // ==========================================================
  // Observation of outputs and link
  always @(posedge clk)
  begin
    cyc++;
    if (acc_start === 1'b1)
    begin
      {lat_s, addr_s, bank_s} = {acc_lat, acc_addr, acc_bank};
      wr_s = acc_write;
      n_acc++;
    end
    if (pend) ay_s = link.ball;
    pend = link.cmd inside {LLDMC_READ, LLDMC_WRITE};
    if (pend) ax_s = link.ball;
    if (link.cmd === LLDMC_REFRESH)
    begin
      ref_gap = cyc - ref_last;
      ref_last = cyc;
    end
    if (term_dout === 1'b0) n_off++;
    if (odt_on) chk("term_din", term_din, 1);
  end

  initial
  begin
    repeat (8000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("dll_locked", dll_locked, 0);
    chk("drive_imp", drive_imp, 8);
    chk("addr_bits", addr_bits, 21);
    chk("term_din", term_din, 0);
    go(LLDMC_READ, '0);
    chk("early_read", n_acc, 0);
    mode(mw(0, 0, 0, 1, 0));
    odt_on = 1'b1;
    chk("term_dout", term_dout, 1);
    repeat (1000) @(posedge clk);
    chk("read_allowed", read_allowed, 0);
    repeat (40) @(posedge clk);
    chk("dll_locked", dll_locked, 1);
    chk("read_allowed", read_allowed, 1);
    n_off = 0;
    for (int c = 0; c < 6; c++)
    begin
      mode(mw(c[2:0], 0, 0, 1, 0));
      go(LLDMC_WRITE, 21'h1C0155);
      chk("write_lat", lat_s, rl_tab[c] + 1);
      chk("write_flag", wr_s, 1);
      chk("addr", addr_s, 21'h1C0155);
      go(LLDMC_READ, 21'h002AA);
      chk("read_lat", lat_s, rl_tab[c]);
      chk("read_flag", wr_s, 0);
    end
    repeat (16) @(posedge clk);
    chk("term_off_seen", n_off != 0, 1);
    chk("term_dout", term_dout, 1);
    for (int w = 0; w < 2; w++)
      for (int b = 0; b < 3; b++)
      begin
        wide_part <= w[0];
        mode(mw(2, b[1:0], 0, 1, 0));
        chk("burst_sel", burst_sel, b);
        chk("addr_bits", addr_bits, 21 - b - w);
        go(LLDMC_WRITE, 21'h1FFFFF);
        chk("addr_mask", addr_s, (1 << (21 - b - w)) - 1);
      end
    ext_imp_code <= 4'h5;
    mode(mw(2, 0, 0, 1, 1));
    go(LLDMC_WRITE, '0);
    chk("imp_lat", lat_s, 7);
    repeat (IMP_PERIOD_CYC + 8) @(posedge clk);
    chk("drive_imp", drive_imp, 5);
    ext_imp_code <= 4'h3;
    repeat (IMP_PERIOD_CYC + 8) @(posedge clk);
    chk("drive_imp", drive_imp, 3);
    mode(mw(2, 0, 0, 1, 0));
    repeat (IMP_PERIOD_CYC + 8) @(posedge clk);
    chk("drive_imp", drive_imp, 8);
    mode(mw(2, 0, 0, 0, 0));
    chk("dll_locked", dll_locked, 0);
    chk("read_allowed", read_allowed, 0);
    mode(mw(2, 0, 0, 1, 0));
    repeat (1040) @(posedge clk);
    chk("read_allowed", read_allowed, 1);
    wide_part <= 1'b0;
    mode(mw(0, 0, 1, 1, 0));
    chk("mux_mode", mux_mode, 1);
    go(LLDMC_WRITE, A);
    chk("mux_addr", addr_s, A);
    chk("mux_wlat", lat_s, 6);
    chk("mux_bank", bank_s, 5);
    chk("first_part", ax_s & 19'h66739, A[18:0] & 19'h66739);
    chk("second_part", ay_s & 19'h66719, ay_exp(A) & 19'h66719);
    go(LLDMC_READ, A);
    chk("mux_rlat", lat_s, 5);
    req(LLDMC_REFRESH, '0, '0);
    req(LLDMC_REFRESH, '0, '0);
    idle();
    repeat (2) @(posedge clk);
    chk("refresh_gap", ref_gap, 1);
    wide_part <= 1'b1;
    mode(mw(2, 2, 1, 1, 0));
    go(LLDMC_WRITE, A);
    chk("mux_addr8", addr_s, A & 21'h03FFFF);
    print_verdict();
  end
endmodule
`default_nettype wire
